/* verilog/dpa_pkg.sv */
package dpa_pkg;
  // ************************************************************
  // Timing
  // ************************************************************
  localparam int unsigned CLK_FREQ_HZ = 10_000_000;
  localparam int unsigned CLK_PERIOD_NS = 100;
  localparam int unsigned TAG_PULSE_NS = 400;
  localparam int unsigned TAG_PULSE_CYC =
    (TAG_PULSE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int unsigned TICK_PERIOD_MS = 1300;
  localparam int unsigned TICK_PERIOD_CYC = TICK_PERIOD_MS * (CLK_FREQ_HZ / 1000);
  localparam int unsigned TIMEOUT_MAX_MS = 20800;
  localparam int unsigned PRESET_STEPS = TIMEOUT_MAX_MS / TICK_PERIOD_MS;
  localparam int unsigned PRESET_W = 4;
  localparam int unsigned PULSE_W = 3;
  localparam int unsigned SYNC_STAGES = 2;
  localparam logic [PRESET_W-1:0] PRESET_RESET = 4'h0;

  // ************************************************************
  // Switch decode
  // ************************************************************
  typedef enum logic [1:0] {
    DPA_MODE_OFF,
    DPA_MODE_FORCE_B,
    DPA_MODE_FORCE_A,
    DPA_MODE_AUTO
  } dpa_mode_e;
endpackage

/* verilog/dpa_failsafe.sv */
`timescale 1ns/1ps
module dpa_failsafe
  import dpa_pkg::*;
#(
  parameter int unsigned PULSE_CYC = TAG_PULSE_CYC
) (
  input wire logic i_clk_sys,
  input wire logic i_reset_n,
  input wire logic i_tick,
  input wire logic i_owner_connected,
  input wire logic i_other_request,
  input wire logic i_owner_tag,
  input wire logic [dpa_pkg::PRESET_W-1:0] i_preset,
  output logic o_timeout
);
  import dpa_pkg::*;

  logic [PULSE_W-1:0] pulse_reg;
  logic [PULSE_W-1:0] pulse_next;
  logic [PRESET_W:0] count_reg;
  logic [PRESET_W:0] count_next;
  logic counting_reg;
  logic counting_next;
  logic tag_d_reg;
  logic armed;
  logic tag_rise;
  logic pulse_end;
  logic [PRESET_W:0] load_val;

  // ************************************************************
  // Tag one-shot and timer
  // ************************************************************
  assign armed = i_owner_connected && i_other_request;
  assign tag_rise = i_owner_tag && !tag_d_reg;
  assign pulse_end = (pulse_reg == PULSE_W'(1));
  // Preset 0 still yields one tick, so at most one full step
  assign load_val = {1'b0, i_preset} + (PRESET_W+1)'(1);

  always_comb begin
    pulse_next = pulse_reg;
    counting_next = counting_reg;
    count_next = count_reg;
    o_timeout = 1'b0;
    if (!armed) begin
      pulse_next = '0;
      counting_next = 1'b0;
      count_next = load_val;
    end else if (tag_rise) begin
      pulse_next = PULSE_W'(PULSE_CYC);
      counting_next = 1'b0;
      count_next = load_val;
    end else begin
      if (pulse_reg != '0) begin
        pulse_next = pulse_reg - PULSE_W'(1);
      end
      if (pulse_end) begin
        counting_next = 1'b1;
      end
      if (counting_reg && i_tick) begin
        if (count_reg == (PRESET_W+1)'(1)) begin
          o_timeout = 1'b1;
          counting_next = 1'b0;
          count_next = load_val;
        end else begin
          count_next = count_reg - (PRESET_W+1)'(1);
        end
      end
    end
  end

  always_ff @(posedge i_clk_sys or negedge i_reset_n) begin
    if (!i_reset_n) begin
      pulse_reg <= '0;
      counting_reg <= 1'b0;
      count_reg <= '0;
      tag_d_reg <= 1'b0;
    end else begin
      pulse_reg <= pulse_next;
      counting_reg <= counting_next;
      count_reg <= count_next;
      tag_d_reg <= i_owner_tag;
    end
  end
endmodule

/* verilog/dpa_arbiter.sv */
`timescale 1ns/1ps
module dpa_arbiter
  import dpa_pkg::*;
#(
  parameter int unsigned TICK_CYC = TICK_PERIOD_CYC,
  parameter int unsigned PULSE_CYC = TAG_PULSE_CYC
) (
  input wire logic i_clk_sys,
  input wire logic i_reset_n,
  input wire logic i_online,
  input wire logic i_sequence_a,
  input wire logic i_sequence_b,
  input wire logic i_first_cable_terminator_present,
  input wire logic i_second_cable_terminator_present,
  input wire logic i_switch_a,
  input wire logic i_switch_b,
  input wire logic i_select_a,
  input wire logic i_select_b,
  input wire logic i_request_a,
  input wire logic i_request_b,
  input wire logic i_tag_a,
  input wire logic i_tag_b,
  input wire logic [dpa_pkg::PRESET_W-1:0] i_timer_preset,
  input wire logic i_panel_read_only,
  input wire logic i_attention_event,
  input wire logic i_attention_clear,
  output logic o_power_sequence_enable,
  output logic o_selected_a,
  output logic o_selected_b,
  output logic o_connected_a,
  output logic o_connected_b,
  output logic o_auto_mode,
  output logic o_force_a,
  output logic o_force_b,
  output logic o_degate,
  output logic o_receivers_enable,
  output logic o_write_protect,
  output logic o_request_other_a,
  output logic o_request_other_b,
  output logic o_attention_a,
  output logic o_attention_b
);
  import dpa_pkg::*;

  localparam int unsigned TICK_W = $clog2(TICK_CYC + 1);

  // ************************************************************
  // Input synchronisers
  // ************************************************************
  logic [SYNC_STAGES-1:0] req_a_sync_reg;
  logic [SYNC_STAGES-1:0] req_b_sync_reg;
  logic [SYNC_STAGES-1:0] tag_a_sync_reg;
  logic [SYNC_STAGES-1:0] tag_b_sync_reg;
  logic req_a;
  logic req_b;
  logic tag_a;
  logic tag_b;

  // Request and tag cross cables from unrelated controllers
  always_ff @(posedge i_clk_sys or negedge i_reset_n) begin
    if (!i_reset_n) begin
      req_a_sync_reg <= '0;
      req_b_sync_reg <= '0;
      tag_a_sync_reg <= '0;
      tag_b_sync_reg <= '0;
    end else begin
      req_a_sync_reg <= {req_a_sync_reg[SYNC_STAGES-2:0], i_request_a};
      req_b_sync_reg <= {req_b_sync_reg[SYNC_STAGES-2:0], i_request_b};
      tag_a_sync_reg <= {tag_a_sync_reg[SYNC_STAGES-2:0], i_tag_a};
      tag_b_sync_reg <= {tag_b_sync_reg[SYNC_STAGES-2:0], i_tag_b};
    end
  end

  assign req_a = req_a_sync_reg[SYNC_STAGES-1];
  assign req_b = req_b_sync_reg[SYNC_STAGES-1];
  assign tag_a = tag_a_sync_reg[SYNC_STAGES-1];
  assign tag_b = tag_b_sync_reg[SYNC_STAGES-1];

  // ************************************************************
  // Timer tick divider
  // ************************************************************
  logic [TICK_W-1:0] tick_cnt_reg;
  logic tick;

  assign tick = (tick_cnt_reg == TICK_W'(TICK_CYC - 1));

  always_ff @(posedge i_clk_sys or negedge i_reset_n) begin
    if (!i_reset_n) begin
      tick_cnt_reg <= '0;
    end else if (tick) begin
      tick_cnt_reg <= '0;
    end else begin
      tick_cnt_reg <= tick_cnt_reg + TICK_W'(1);
    end
  end

  // ************************************************************
  // Manual control
  // ************************************************************
  logic en_a_reg;
  logic en_b_reg;
  logic conn_a_reg;
  logic conn_b_reg;
  logic hold_latches;
  logic io_enabled;
  dpa_mode_e mode;

  assign hold_latches = (conn_a_reg && tag_a) || (conn_b_reg && tag_b);

  // Latches only follow switches between operations
  always_ff @(posedge i_clk_sys or negedge i_reset_n) begin
    if (!i_reset_n) begin
      en_a_reg <= 1'b0;
      en_b_reg <= 1'b0;
    end else if (!hold_latches) begin
      en_a_reg <= i_switch_a;
      en_b_reg <= i_switch_b;
    end
  end

  assign mode = dpa_mode_e'({en_a_reg, en_b_reg});
  assign io_enabled = i_online && (mode != DPA_MODE_OFF);
  assign o_degate = (mode == DPA_MODE_OFF);
  assign o_auto_mode = io_enabled && (mode == DPA_MODE_AUTO);
  assign o_force_a = io_enabled && (mode == DPA_MODE_FORCE_A);
  assign o_force_b = io_enabled && (mode == DPA_MODE_FORCE_B);

  // ************************************************************
  // Power sequence enable
  // ************************************************************
  logic seq_requested;
  logic both_term;

  assign seq_requested = i_sequence_a || i_sequence_b;
  assign both_term = i_first_cable_terminator_present
    && i_second_cable_terminator_present;
  // Offline the exerciser owns sequencing
  assign o_power_sequence_enable = !i_online || (seq_requested && both_term);

  // ************************************************************
  // Auto control and lock-out
  // ************************************************************
  logic timeout_a;
  logic timeout_b;
  logic conn_a_next;
  logic conn_b_next;

  dpa_failsafe #(
    .PULSE_CYC(PULSE_CYC)
  ) u_failsafe_a (
    .i_clk_sys(i_clk_sys),
    .i_reset_n(i_reset_n),
    .i_tick(tick),
    .i_owner_connected(conn_a_reg),
    .i_other_request(req_b),
    .i_owner_tag(tag_a),
    .i_preset(i_timer_preset),
    .o_timeout(timeout_a)
  );

  dpa_failsafe #(
    .PULSE_CYC(PULSE_CYC)
  ) u_failsafe_b (
    .i_clk_sys(i_clk_sys),
    .i_reset_n(i_reset_n),
    .i_tick(tick),
    .i_owner_connected(conn_b_reg),
    .i_other_request(req_a),
    .i_owner_tag(tag_b),
    .i_preset(i_timer_preset),
    .o_timeout(timeout_b)
  );

  always_comb begin
    conn_a_next = conn_a_reg;
    conn_b_next = conn_b_reg;
    if (o_force_a) begin
      conn_a_next = 1'b1;
      conn_b_next = 1'b0;
    end else if (o_force_b) begin
      conn_a_next = 1'b0;
      conn_b_next = 1'b1;
    end else if (!o_auto_mode) begin
      conn_a_next = 1'b0;
      conn_b_next = 1'b0;
    end else begin
      // Owner releases on dropped request or on expiry
      if (conn_a_reg && (!req_a || timeout_a)) begin
        conn_a_next = 1'b0;
      end
      if (conn_b_reg && (!req_b || timeout_b)) begin
        conn_b_next = 1'b0;
      end
      // A wins a tie, so both are never granted
      if (!conn_a_next && !conn_b_next) begin
        if (req_a && !(conn_a_reg && timeout_a)) begin
          conn_a_next = 1'b1;
        end else if (req_b && !(conn_b_reg && timeout_b)) begin
          conn_b_next = 1'b1;
        end
      end
    end
  end

  always_ff @(posedge i_clk_sys or negedge i_reset_n) begin
    if (!i_reset_n) begin
      conn_a_reg <= 1'b0;
      conn_b_reg <= 1'b0;
    end else begin
      conn_a_reg <= conn_a_next;
      conn_b_reg <= conn_b_next;
    end
  end

  assign o_connected_a = conn_a_reg;
  assign o_connected_b = conn_b_reg;

  // ************************************************************
  // Selection
  // ************************************************************
  assign o_selected_a = i_select_a && en_a_reg && conn_a_reg;
  assign o_selected_b = i_select_b && en_b_reg && conn_b_reg;
  assign o_receivers_enable = o_selected_a || o_selected_b;
  assign o_write_protect = !o_receivers_enable && i_panel_read_only;

  // ************************************************************
  // Request indication and attention
  // ************************************************************
  logic att_a_reg;
  logic att_b_reg;
  logic rise_a;
  logic rise_b;

  assign o_request_other_a = req_b;
  assign o_request_other_b = req_a;
  assign rise_a = conn_a_next && !conn_a_reg;
  assign rise_b = conn_b_next && !conn_b_reg;

  // Set wins over the clear shared by both ports
  always_ff @(posedge i_clk_sys or negedge i_reset_n) begin
    if (!i_reset_n) begin
      att_a_reg <= 1'b0;
      att_b_reg <= 1'b0;
    end else begin
      if (!conn_a_next) begin
        att_a_reg <= 1'b0;
      end else if (rise_a || i_attention_event) begin
        att_a_reg <= 1'b1;
      end else if (i_attention_clear) begin
        att_a_reg <= 1'b0;
      end
      if (!conn_b_next) begin
        att_b_reg <= 1'b0;
      end else if (rise_b || i_attention_event) begin
        att_b_reg <= 1'b1;
      end else if (i_attention_clear) begin
        att_b_reg <= 1'b0;
      end
    end
  end

  assign o_attention_a = att_a_reg;
  assign o_attention_b = att_b_reg;
endmodule

/* sim/dpa_arbiter_monitor.sv */
`timescale 1ns/1ps
// ************************************************************
// Port checker
// ************************************************************
module dpa_arbiter_monitor (
  input wire logic i_clk_sys,
  input wire logic i_reset_n,
  input wire logic i_online,
  input wire logic i_first_cable_terminator_present,
  input wire logic i_second_cable_terminator_present,
  input wire logic i_switch_a,
  input wire logic i_switch_b,
  input wire logic i_select_a,
  input wire logic i_request_a,
  input wire logic o_power_sequence_enable,
  input wire logic o_selected_a,
  input wire logic o_selected_b,
  input wire logic o_connected_a,
  input wire logic o_connected_b,
  input wire logic o_auto_mode,
  input wire logic o_force_a,
  input wire logic o_force_b,
  input wire logic o_degate,
  input wire logic o_receivers_enable,
  input wire logic o_write_protect,
  input wire logic o_request_other_b,
  input wire logic o_attention_a
);
  default clocking @(posedge i_clk_sys); endclocking
  default disable iff (!i_reset_n);
  AST_PWR: assert property (i_online && !(i_first_cable_terminator_present
    && i_second_cable_terminator_present) |-> !o_power_sequence_enable)
    else $error("power enable without both terminators");
  AST_SEL: assert property (o_selected_a |-> i_select_a && o_connected_a)
    else $error("selected without select and connect");
  AST_RX: assert property (o_selected_a || o_selected_b |-> o_receivers_enable &&
    !o_write_protect) else $error("receivers or panel wrong while selected");
  AST_MUTEX: assert property (!(o_connected_a && o_connected_b))
    else $error("both ports connected");
  AST_DEGATE: assert property (!i_switch_a && !i_switch_b && !o_connected_a &&
    !o_connected_b |=> o_degate) else $error("no degate with both switches off");
  AST_FORCE: assert property (o_force_a |-> !o_auto_mode && !o_force_b)
    else $error("force with auto or other force");
  AST_REQO: assert property ($rose(i_request_a) |-> ##[1:3] o_request_other_b)
    else $error("request not passed to other side");
  AST_ATTN_ON: assert property ($rose(o_connected_a) |-> o_attention_a)
    else $error("no attention on connect");
  AST_ATTN_OFF: assert property (!o_connected_a |-> !o_attention_a)
    else $error("attention while not connected");
  cover property ($rose(o_connected_a));
  cover property (o_selected_a);
  cover property (o_force_a);
endmodule

bind dpa_arbiter dpa_arbiter_monitor u_mon (.i_clk_sys, .i_reset_n, .i_online,
  .i_first_cable_terminator_present, .i_second_cable_terminator_present, .i_switch_a,
  .i_switch_b, .i_select_a, .i_request_a, .o_power_sequence_enable, .o_selected_a,
  .o_selected_b, .o_connected_a, .o_connected_b, .o_auto_mode, .o_force_a, .o_force_b,
  .o_degate, .o_receivers_enable, .o_write_protect, .o_request_other_b, .o_attention_a);

/* sim/dpa_ctrl_model.sv */
`timescale 1ns/1ps
// ************************************************************
// Controller on one port
// ************************************************************
module dpa_ctrl_model #(
  parameter int TAG_GAP = 8
) (
  input wire logic i_clk_sys,
  input wire logic i_need,
  input wire logic i_work,
  output logic o_request,
  output logic o_tag,
  output logic o_select
);
  int cnt = 0;
  initial begin
    o_request = 1'b0;
    o_tag = 1'b0;
    o_select = 1'b0;
  end
  // Short tags, so each one is a fresh rise for the timer
  always @(negedge i_clk_sys) begin
    cnt <= (cnt == TAG_GAP - 1) ? 0 : cnt + 1;
    o_request <= i_need;
    o_select <= i_need;
    o_tag <= i_work && cnt == 0;
  end
endmodule

/* sim/dpa_arbiter_tb_top.sv */
`timescale 1ns/1ps
`define CHK(a, b) begin comparisons++; if ((a) !== (b)) begin err_total++; \
  $display("wrong value t=%0t got %b exp %b", $time, a, b); end end
module dpa_arbiter_tb_top;
  import dpa_pkg::*;
  // ************************************************************
  // Bench
  // ************************************************************
  localparam int TICK = 20;
  logic clk = 0, rst_n = 0, online = 1, term1 = 1, term2 = 1, sw_a = 1, sw_b = 1;
  logic need_a = 0, need_b = 0, work_a = 0, ro = 1, att_ev = 0, att_clr = 0;
  logic [PRESET_W-1:0] preset = 4'h2;
  logic req_a, req_b, tag_a, tag_b, sel_a, sel_b, pwr, sld_a, sld_b, conn_a, conn_b;
  logic am, frc_a, frc_b, dgt, rx_en, wp, ro_a, ro_b, att_a, att_b;
  logic [3:0] exp_mode [4] = '{4'h1, 4'h2, 4'h4, 4'h8};
  int err_total = 0, comparisons = 0, n;
  always #50 clk = ~clk;
  dpa_ctrl_model u_ctrl_a (.i_clk_sys(clk), .i_need(need_a), .i_work(work_a),
    .o_request(req_a), .o_tag(tag_a), .o_select(sel_a));
  dpa_ctrl_model u_ctrl_b (.i_clk_sys(clk), .i_need(need_b), .i_work(1'b0),
    .o_request(req_b), .o_tag(tag_b), .o_select(sel_b));
  dpa_arbiter #(.TICK_CYC(TICK)) u_dpa_arbiter (.i_clk_sys(clk), .i_reset_n(rst_n),
    .i_online(online), .i_sequence_a(1'b1), .i_sequence_b(1'b0),
    .i_first_cable_terminator_present(term1), .i_second_cable_terminator_present(term2),
    .i_switch_a(sw_a), .i_switch_b(sw_b), .i_select_a(sel_a), .i_select_b(sel_b),
    .i_request_a(req_a), .i_request_b(req_b), .i_tag_a(tag_a), .i_tag_b(tag_b),
    .i_timer_preset(preset), .i_panel_read_only(ro), .i_attention_event(att_ev),
    .i_attention_clear(att_clr), .o_power_sequence_enable(pwr), .o_selected_a(sld_a),
    .o_selected_b(sld_b), .o_connected_a(conn_a), .o_connected_b(conn_b),
    .o_auto_mode(am), .o_force_a(frc_a), .o_force_b(frc_b), .o_degate(dgt),
    .o_receivers_enable(rx_en), .o_write_protect(wp), .o_request_other_a(ro_a),
    .o_request_other_b(ro_b), .o_attention_a(att_a), .o_attention_b(att_b));

  task automatic complete_run();
    $display("comparisons=%0d err_total=%0d", comparisons, err_total);
    if (err_total == 0 && comparisons > 0) begin
      $display("ALL CHECKS OK");
    end else begin
      $display("CHECKS NOT OK");
    end
    $finish;
  endtask

  // Bounded wait for a port to connect, cycles counted in n
  task automatic wconn(input bit b, input int lim);
    for (n = 0; n < lim && (b ? conn_b : conn_a) !== 1'b1; n++) @(negedge clk);
    if (n == lim) begin
      err_total++;
      $display("wrong value t=%0t no connect", $time);
      complete_run();
    end
  endtask

  initial begin
    repeat (16) @(negedge clk);
    rst_n = 1;
    repeat (3) @(negedge clk);
    `CHK({am, frc_a, frc_b, dgt}, 4'h8)
    `CHK(pwr, 1'b1)
    term2 = 0;
    #1 `CHK(pwr, 1'b0)
    online = 0;
    #1 `CHK(pwr, 1'b1)
    online = 1;
    term2 = 1;
    $display("test power done");
    // Nonblocking, so both port models see a change on the same edge
    need_a <= 1;
    wconn(0, 10);
    `CHK(att_a, 1'b1)
    `CHK(ro_b, 1'b1)
    @(negedge clk);
    `CHK(sld_a, 1'b1)
    `CHK({rx_en, wp}, 2'b10)
    `CHK(att_b, 1'b0)
    $display("test free connect done");
    work_a <= 1;
    need_b <= 1;
    repeat (100) @(negedge clk);
    `CHK(conn_a, 1'b1)
    `CHK({sld_b, ro_a}, 2'b01)
    work_a <= 0;
    wconn(1, 120);
    `CHK(n >= (preset + 1) * TICK - TICK - 10 && n <= (preset + 1) * TICK + TICK, 1'b1)
    `CHK({conn_a, att_b, att_a}, 3'b010)
    $display("test timeout done");
    att_clr <= 1;
    @(negedge clk);
    att_clr <= 0;
    `CHK(att_b, 1'b0)
    att_ev <= 1;
    @(negedge clk);
    att_ev <= 0;
    `CHK({att_b, att_a}, 2'b10)
    $display("test attention done");
    need_a <= 0;
    need_b <= 0;
    repeat (10) @(negedge clk);
    need_a <= 1;
    need_b <= 1;
    wconn(0, 10);
    `CHK(conn_b, 1'b0)
    need_a <= 0;
    need_b <= 0;
    $display("test same cycle done");
    for (int i = 0; i < 4; i++) begin
      {sw_a, sw_b} = i[1:0];
      repeat (6) @(negedge clk);
      `CHK({am, frc_a, frc_b, dgt}, exp_mode[i])
      if (i == 2) `CHK(conn_a, 1'b1)
    end
    $display("test switches done");
    complete_run();
  end
endmodule
